// ---- logic/pll_serial_load.sv ----
// serial load, counter source select and lock detect of the synthesizer
// Functional notes
// - shifting happens only while the load strobe is low
// - strobe rising edge copies the first-stage register into the second
// - enhancement select low: shift data into 20-bit first-stage register
// - enhancement select high: shift data into 8-bit enhancement register
// - source select 1 uses first-stage word, 0 uses second-stage word
// - enhancement bits act only while the enhancement mode pin is low
// - filter node carries nand of pump up and pump down pulses
// - lock output is open drain, following the filtered node level
// - locked releases the lock pin; otherwise it pulls low
// - diagnostic output enabled only in enhancement mode, enh bits select
// - charge pump sources when feedback leads, sinks when it lags
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pll_serial_map.svh"
module pll_serial_load
  import pll_serial_pkg::*;
#(
  parameter int FIRST_W = 20,
  parameter int ENH_W   = 8
) (
  input  wire  logic               CLK,
  input  wire  logic               RESET,
  input  wire  logic               SCLK,
  input  wire  logic               SDATA,
  input  wire  logic               SLOAD,
  input  wire  logic               ENH_SEL,
  input  wire  logic               SRC_SEL,
  input  wire  logic               ENH_MODE_N,
  input  wire  logic               PUMP_UP,
  input  wire  logic               PUMP_DOWN,
  output logic [FIRST_W-1:0]       COUNTER_WORD,
  output logic [ENH_W-1:0]         ENH_BITS,
  output logic                     CEXT,
  output logic                     LOCK_O,
  output logic                     LOCK_OE,
  output logic                     DIAG_O,
  output logic                     DIAG_OE,
  output logic                     CHARGE_PUMP_SOURCE,
  output logic                     CHARGE_PUMP_SINK,
  output logic                     IRQ,
  input  wire  logic               HSEL,
  input  wire  logic [31:0]        HADDR,
  input  wire  logic [1:0]         HTRANS,
  input  wire  logic               HWRITE,
  input  wire  logic [2:0]         HSIZE,
  input  wire  logic               HREADY,
  input  wire  logic [31:0]        HWDATA,
  output logic [31:0]              HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP
);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // pin synchronisers, bit order matches the raw vector
  logic [`PINS_WIDTH-1:0] pin_raw;
  logic [`PINS_WIDTH-1:0] meta_q;
  logic [`PINS_WIDTH-1:0] sync_q;
  logic                   sclk_prev_q;
  logic                   sload_prev_q;

  assign pin_raw = {PUMP_DOWN, PUMP_UP, ENH_MODE_N, SRC_SEL,
                    ENH_SEL, SLOAD, SDATA, SCLK};

  always_ff @(posedge CLK) begin
    if (RESET) begin
      meta_q <= `PINS_RST;
      sync_q <= `PINS_RST;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  logic sclk_s;
  logic sdata_s;
  logic sload_s;
  logic enh_sel_s;
  logic src_sel_s;
  logic enh_mode_n_s;
  logic up_s;
  logic down_s;
  assign {down_s, up_s, enh_mode_n_s, src_sel_s,
          enh_sel_s, sload_s, sdata_s, sclk_s} = sync_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sclk_prev_q  <= 1'b0;
      sload_prev_q <= 1'b1;
    end else begin
      sclk_prev_q  <= sclk_s;
      sload_prev_q <= sload_s;
    end
  end

  logic sclk_rise;
  logic sload_rise;
  logic shift_ok;
  assign sclk_rise  = sclk_s & ~sclk_prev_q;
  assign sload_rise = sload_s & ~sload_prev_q;
  assign shift_ok   = sclk_rise & ~sload_s;

  // shift registers, msb first
  logic [FIRST_W-1:0] first_q;
  logic [FIRST_W-1:0] second_q;
  logic [ENH_W-1:0]   enh_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      first_q <= '0;
    end else if (shift_ok && !enh_sel_s) begin
      first_q <= {first_q[FIRST_W-2:0], sdata_s};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      enh_q <= '0;
    end else if (shift_ok && enh_sel_s) begin
      enh_q <= {enh_q[ENH_W-2:0], sdata_s};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      second_q <= '0;
    end else if (sload_rise) begin
      second_q <= first_q;
    end
  end

  // counter source and enhancement gating
  always_ff @(posedge CLK) begin
    if (RESET) begin
      COUNTER_WORD <= '0;
      ENH_BITS     <= '0;
    end else begin
      COUNTER_WORD <= src_sel_s ? first_q : second_q;
      ENH_BITS     <= enh_mode_n_s ? '0 : enh_q;
    end
  end

  // phase error node, lock filter and charge pump direction
  logic [7:0] thresh_q;
  logic [7:0] cnt_q;
  logic       locked_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      CEXT               <= 1'b1;
      CHARGE_PUMP_SOURCE <= 1'b0;
      CHARGE_PUMP_SINK   <= 1'b0;
    end else begin
      CEXT               <= ~(up_s & down_s);
      CHARGE_PUMP_SOURCE <= up_s & ~down_s;
      CHARGE_PUMP_SINK   <= down_s & ~up_s;
    end
  end

  // digital stand-in for the external capacitor
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt_q <= '0;
    end else if (!CEXT) begin
      cnt_q <= '0;
    end else if (cnt_q < thresh_q) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= CEXT && (cnt_q >= thresh_q);
    end
  end

  assign LOCK_O  = 1'b0;
  assign LOCK_OE = ~locked_q;

  // diagnostic output
  diag_sel_e diag_sel;
  logic      diag_d;
  assign diag_sel = diag_sel_e'(enh_q[1:0]);

  always_comb begin
    case (diag_sel)
      DIAG_LOCK:      diag_d = locked_q;
      DIAG_CEXT:      diag_d = CEXT;
      DIAG_FIRST_MSB: diag_d = first_q[FIRST_W-1];
      default:        diag_d = up_s;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      DIAG_O  <= 1'b0;
      DIAG_OE <= 1'b0;
    end else begin
      DIAG_O  <= enh_mode_n_s ? 1'b0 : diag_d;
      DIAG_OE <= ~enh_mode_n_s;
    end
  end

  // ahb-lite slave, zero wait states
  logic              rd_take;
  logic              wr_take;
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  logic [7:0]        addr;
  logic [`EV_WIDTH-1:0] status_q;
  logic [`EV_WIDTH-1:0] mask_q;
  logic [`EV_WIDTH-1:0] ev;
  logic [`EV_WIDTH-1:0] clr;
  logic              locked_prev_q;
  logic [31:0]       rdata_d;

  assign addr    = HADDR[7:0];
  assign rd_take = HSEL & HTRANS[1] & HREADY & ~HWRITE;
  assign wr_take = HSEL & HTRANS[1] & HREADY & HWRITE;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= addr;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      mask_q   <= `MASK_RST;
      thresh_q <= `LOCK_THRESH_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `OFS_MASK) begin
        mask_q <= HWDATA[`EV_WIDTH-1:0];
      end else if (wr_addr_q == `OFS_LOCK_THRESH) begin
        thresh_q <= HWDATA[7:0];
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addr == `OFS_STATUS) begin
      rdata_d[`EV_WIDTH-1:0] = status_q;
    end else if (addr == `OFS_MASK) begin
      rdata_d[`EV_WIDTH-1:0] = mask_q;
    end else if (addr == `OFS_LOCK_THRESH) begin
      rdata_d[7:0] = thresh_q;
    end else if (addr == `OFS_FIRST) begin
      rdata_d[FIRST_W-1:0] = first_q;
    end else if (addr == `OFS_SECOND) begin
      rdata_d[FIRST_W-1:0] = second_q;
    end else if (addr == `OFS_ENH) begin
      rdata_d[ENH_W-1:0] = enh_q;
    end else if (addr == `OFS_PINS) begin
      rdata_d[7:0] = {locked_q, CEXT, enh_mode_n_s, src_sel_s,
                      enh_sel_s, sload_s, 2'b00};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_take) begin
      HRDATA <= rdata_d;
    end
  end

  // sticky events, read clears, set wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      locked_prev_q <= 1'b0;
    end else begin
      locked_prev_q <= locked_q;
    end
  end

  assign ev  = {~locked_q & locked_prev_q, locked_q & ~locked_prev_q,
                sload_rise};
  assign clr = (rd_take && addr == `OFS_STATUS) ? '1 : '0;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
    end
  end

  assign IRQ = |(status_q & mask_q);

  // checks
  shift_first_a: assert property (
    shift_ok && !enh_sel_s |=>
      first_q == {$past(first_q[FIRST_W-2:0]), $past(sdata_s)})
    else $error("first-stage shift wrong");

  shift_enh_a: assert property (
    shift_ok && enh_sel_s |=>
      enh_q == {$past(enh_q[ENH_W-2:0]), $past(sdata_s)} &&
      $stable(first_q))
    else $error("enhancement shift wrong");

  strobe_block_a: assert property (
    sload_s |=> $stable(first_q) && $stable(enh_q))
    else $error("shift while strobe high");

  load_copy_a: assert property (
    $rose(sload_s) |=> second_q == $past(first_q))
    else $error("strobe did not copy word");

  second_hold_a: assert property (
    !sload_rise |=> $stable(second_q))
    else $error("second-stage word changed");

  source_sel_a: assert property (
    1'b1 |=> COUNTER_WORD == ($past(src_sel_s) ? $past(first_q)
                                                : $past(second_q)))
    else $error("counter source wrong");

  enh_gate_a: assert property (
    enh_mode_n_s |=> ENH_BITS == '0 && !DIAG_OE)
    else $error("enhancement bits leak");

  cext_nand_a: assert property (
    up_s && down_s |=> !CEXT ##1 !locked_q)
    else $error("nand node wrong");

  lock_pin_a: assert property (
    !CEXT |=> LOCK_OE && !LOCK_O)
    else $error("lock pin released out of lock");

  diag_en_a: assert property (
    !enh_mode_n_s |=> DIAG_OE)
    else $error("diag not enabled");

  pump_dir_a: assert property (
    1'b1 |=> !(CHARGE_PUMP_SOURCE && CHARGE_PUMP_SINK) &&
      CHARGE_PUMP_SOURCE == ($past(up_s) && !$past(down_s)))
    else $error("pump direction wrong");

  irq_set_a: assert property (
    sload_rise && mask_q[`EV_LOAD] |=> IRQ)
    else $error("load event lost");

  load_c:   cover property (sload_rise ##[1:40] sload_rise);
  enh_c:    cover property (shift_ok && enh_sel_s && !enh_mode_n_s);
  lock_c:   cover property ($rose(locked_q));
  unlock_c: cover property ($fell(locked_q));

endmodule
`default_nettype wire

// ---- logic/pll_serial_map.svh ----
// register offsets and reset values of the serial load block
`ifndef PLL_SERIAL_MAP_SVH
`define PLL_SERIAL_MAP_SVH
`define OFS_STATUS      8'h00
`define OFS_MASK        8'h04
`define OFS_LOCK_THRESH 8'h08
`define OFS_FIRST       8'h0C
`define OFS_SECOND      8'h10
`define OFS_ENH         8'h14
`define OFS_PINS        8'h18
`define EV_LOAD         0
`define EV_LOCK_GAIN    1
`define EV_LOCK_LOSS    2
`define EV_WIDTH        3
`define MASK_RST        3'h0
`define LOCK_THRESH_RST 8'h10
`define PINS_WIDTH      8
`define PINS_RST        8'h24
`endif

// ---- logic/pll_serial_pkg.sv ----
// types shared by the serial load block
package pll_serial_pkg;
  typedef enum logic [1:0] {
    DIAG_LOCK,
    DIAG_CEXT,
    DIAG_FIRST_MSB,
    DIAG_PUMP_UP
  } diag_sel_e;
endpackage

// ---- sim/pll_serial_load_and_lock_detect_tb.sv ----
// randomized self-checking bench of the serial load block
`timescale 1ns/1ns
`default_nettype none
`include "pll_serial_map.svh"
module pll_serial_load_and_lock_detect_tb;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        SRC_SEL = 1'b0;
  logic        ENH_MODE_N = 1'b1;
  logic        PUMP_UP = 1'b0;
  logic        PUMP_DOWN = 1'b0;
  logic [31:0] HADDR = '0;
  logic [1:0]  HTRANS = '0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = '0;
  logic [2:0]  HSIZE = 3'h2;
  logic        SCLK, SDATA, SLOAD, ENH_SEL, CEXT, LOCK_O, LOCK_OE, DIAG_O;
  logic        DIAG_OE, CHARGE_PUMP_SOURCE, CHARGE_PUMP_SINK, IRQ;
  logic        HREADYOUT, HRESP;
  logic [19:0] COUNTER_WORD;
  logic [7:0]  ENH_BITS;
  logic [31:0] HRDATA, rd, w, v;
  logic [31:0] seed = 32'h0000_0041;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #50 CLK = ~CLK;
  serial_host h (.CLK(CLK), .SCLK(SCLK), .SDATA(SDATA), .SLOAD(SLOAD),
                 .ENH_SEL(ENH_SEL));
  pll_serial_load DUT (.CLK(CLK), .RESET(RESET), .SCLK(SCLK),
    .SDATA(SDATA), .SLOAD(SLOAD), .ENH_SEL(ENH_SEL), .SRC_SEL(SRC_SEL),
    .ENH_MODE_N(ENH_MODE_N), .PUMP_UP(PUMP_UP), .PUMP_DOWN(PUMP_DOWN),
    .COUNTER_WORD(COUNTER_WORD), .ENH_BITS(ENH_BITS), .CEXT(CEXT),
    .LOCK_O(LOCK_O), .LOCK_OE(LOCK_OE), .DIAG_O(DIAG_O), .DIAG_OE(DIAG_OE),
    .CHARGE_PUMP_SOURCE(CHARGE_PUMP_SOURCE),
    .CHARGE_PUMP_SINK(CHARGE_PUMP_SINK), .IRQ(IRQ), .HSEL(1'b1),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP));
  function automatic logic [31:0] pick(logic s, logic [31:0] a,
                                       logic [31:0] b);
    return s ? a : b;
  endfunction
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // diag pin: low outside enhancement mode; lock and node idle high
  function automatic logic [31:0] diag_exp(logic m, logic [1:0] s,
                                           logic top);
    if (m) return 32'h0000_0000;
    return {31'h0000_0000, (s == 2'h2) ? top : (s != 2'h3)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    HTRANS <= 2'b10;
    HADDR <= {24'h00_0000, a};
    HWRITE <= wr;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    r = HRDATA;
    chk(HRESP, 32'h0000_0000);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
    chk(ENH_BITS, 0);
    chk(DIAG_OE, 0);
    chk(COUNTER_WORD, 0);
    ahb(0, `OFS_LOCK_THRESH, 0, rd);
    chk(rd, `LOCK_THRESH_RST);
    ahb(0, 8'h1C, 0, rd);
    chk(rd, 0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      w = rnd() & 32'h000F_FFFF;
      if (i == 0) w = 32'h000F_FFFF;
      h.send(w[19:0], 20, 1'b0, 1'b1, 1'b1);
      ahb(0, `OFS_FIRST, 0, rd);
      chk(rd, w);
      ahb(0, `OFS_SECOND, 0, rd);
      chk(rd, w);
      chk(IRQ, 0);
      ahb(0, `OFS_STATUS, 0, rd);
      chk(rd[0], 1);
      ahb(0, `OFS_STATUS, 0, rd);
      chk(rd, 0);
    end
    $display("test load done");
    ahb(1, `OFS_MASK, 7, rd);
    v = rnd() & 32'h000F_FFFF;
    h.send(v[19:0], 20, 1'b0, 1'b1, 1'b0);
    ahb(0, `OFS_SECOND, 0, rd);
    chk(rd, w);
    for (int s = 0; s < 2; s++) begin
      SRC_SEL <= s[0];
      repeat (6) @(posedge CLK);
      chk(COUNTER_WORD, pick(s[0], v, w));
    end
    h.send(v[19:0], 0, 1'b0, 1'b1, 1'b1);
    chk(COUNTER_WORD, v);
    chk(IRQ, 1);
    ahb(0, `OFS_STATUS, 0, rd);
    chk(IRQ, 0);
    $display("test hold done");
    w = rnd();
    h.send(w[19:0], 20, 1'b0, 1'b0, 1'b1);
    ahb(0, `OFS_FIRST, 0, rd);
    chk(rd, v);
    for (int m = 0; m < 2; m++) begin
      ENH_MODE_N <= m[0];
      w = rnd();
      h.send(w[19:0], 8, 1'b1, 1'b1, 1'b1);
      ahb(0, `OFS_ENH, 0, rd);
      chk(rd, w[7:0]);
      ahb(0, `OFS_FIRST, 0, rd);
      chk(rd, v);
      chk(ENH_BITS, pick(m[0], 0, w[7:0]));
      chk(DIAG_OE, !m[0]);
      chk(DIAG_O, diag_exp(m[0], w[1:0], v[19]));
    end
    $display("test enhancement done");
    for (int i = 0; i < 4; i++) begin
      PUMP_UP <= i[0];
      PUMP_DOWN <= i[1];
      repeat (30) @(posedge CLK);
      chk(CEXT, !(i[0] & i[1]));
      chk(LOCK_OE, i[0] & i[1]);
      chk(LOCK_O, 0);
      chk(CHARGE_PUMP_SOURCE, i[0] & !i[1]);
      chk(CHARGE_PUMP_SINK, i[1] & !i[0]);
    end
    $display("test lock done");
    close_out;
  end
endmodule
`default_nettype wire

// ---- sim/serial_host.sv ----
// host model driving the three-wire serial port
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  input  wire logic CLK,
  output logic      SCLK,
  output logic      SDATA,
  output logic      SLOAD,
  output logic      ENH_SEL
);
  initial begin
    SCLK = 1'b0;
    SDATA = 1'b0;
    SLOAD = 1'b1;
    ENH_SEL = 1'b0;
  end
  // n bits msb first, 800 ns shift clock, strobe raised if stb
  task automatic send(input logic [19:0] w, input int n, input logic enh,
                      input logic low, input logic stb);
    ENH_SEL <= enh;
    SLOAD <= ~low;
    for (int i = n - 1; i >= 0; i--) begin
      SDATA <= w[i];
      repeat (4) @(posedge CLK);
      SCLK <= 1'b1;
      repeat (4) @(posedge CLK);
      SCLK <= 1'b0;
    end
    // no pull on the data line: show the inverse once released
    SDATA <= ~SDATA;
    repeat (4) @(posedge CLK);
    if (stb) SLOAD <= 1'b1;
    repeat (8) @(posedge CLK);
  endtask
endmodule
`default_nettype wire
